// file: hw/arfsi_sync.sv
// Two-flop level synchroniser
module arfsi_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= RST;
      q_out  <= RST;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// file: hw/arfsi_top.sv
// Conversion-result queue: storage, flags, serial readback, checksum
// Operation
// - Readback is 16 command clocks, then 16 or 24 clocks per sample.
// - While the serial side holds the queue, conversions cannot write.
// - Data-out shows busy high while writing, low when readable.
// - Watermark mode: busy until count reaches level; streaming: busy per write.
// - Tag: channel in 3:0, drained 4, level 5, limit 6, bit 7 zero.
// - Tag is sent with each sample unless append-tag is cleared.
// - Tag of the last stored sample read carries the drained flag.
// - Tag level flag marks samples stored at or beyond the fill level.
// - Tag limit flag is per sample, only for limit-checked channels.
// - Append-status sends status byte during the count byte.
// - Drained sets on last sample or empty read, clears on write.
// - Level flag follows count at or above the fill level.
// - Data-lost sets on dropped or overwritten result, clears on empty.
// - Limit flags are sticky until drained or cleared.
// - Read during a write flags read error and returns zeros.
// - Write held one conversion, then write error; also full watermark.
// - Status bit 7 mirrors the controller error bit.
// - Checksum 0xA2EB, init all ones, only with tag on, status off.
// - Checksum after each level-sized block; first covers command too.
// - Interrupt is OR of enabled status sources.
// - Level interrupt on at reset; level zero means 256.
// - Limit interrupts off at reset; clearing drops limit flags.
// - Tripped limit releases only two LSBs inside, on bits 23:12.
// - A control write with queue enabled empties it and resets flags.
module arfsi_top
  import arfsi_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        din_in,
  output logic             dout_out,
  input  wire logic        conv_valid_in,
  input  wire logic [23:0] conv_data_in,
  input  wire logic [3:0]  channel_index_in,
  input  wire logic [15:0] channel_limit_check_enable_in,
  input  wire logic [11:0] upper_limit_value_in,
  input  wire logic [11:0] lower_limit_value_in,
  input  wire logic        ctrl_wr_in,
  input  wire logic [23:0] ctrl_data_in,
  input  wire logic        crc_enable_in,
  input  wire logic        ctrl_err_in,
  output logic      [23:0] ctrl_out,
  output logic      [7:0]  queue_status_out,
  output logic             irq_out
);
  // ----------------------------------------------------------------
  // Reset release and crossings
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  logic cs_n_s;
  logic pop_s;
  logic pop_d_r;
  logic lock_d_r;
  logic pop_tgl_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  arfsi_sync #(.W(2), .RST(2'b10)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_r),
    .d_in     ({cs_n_in, pop_tgl_r}),
    .q_out    ({cs_n_s, pop_s})
  );

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pop_d_r  <= 1'b0;
      lock_d_r <= 1'b0;
    end else begin
      pop_d_r  <= pop_s;
      lock_d_r <= ~cs_n_s;
    end
  end

  // ----------------------------------------------------------------
  // Queue state and decode
  // ----------------------------------------------------------------
  logic [23:0] mem_r [0:255];
  logic [23:0] ctrl_r;
  logic [7:0]  wr_ptr_r;
  logic [7:0]  rd_ptr_r;
  logic [8:0]  cnt_r;
  logic [8:0]  cnt_nxt;
  logic [6:0]  stat_r;
  logic        ctrl_err_r;
  logic        pend_r;
  logic [23:0] pend_data_r;
  logic [3:0]  pend_ch_r;
  logic        hi_trip_r;
  logic        lo_trip_r;
  logic        rd_zero_r;
  logic        rdy_r;
  logic [23:0] stage_word_r;
  logic [7:0]  stage_stat_r;
  logic [11:0] cfg_r;

  logic        lock;
  logic        grant_ev;
  logic        pop_ev;
  logic        fifo_on;
  logic        wm_mode;
  logic [8:0]  wm_n;
  logic        clr;
  logic        do_wr;
  logic        wm_full;
  logic        store;
  logic        ovw;
  logic        do_pop;
  logic        empty_rd;
  logic        last_pop;
  logic        wr_err_ev;
  logic        lim_en;
  logic [12:0] dval;
  logic        cmp_hi;
  logic        cmp_lo;
  logic [23:0] head;

  assign lock     = ~cs_n_s;
  assign grant_ev = lock & ~lock_d_r;
  assign pop_ev   = pop_s ^ pop_d_r;
  assign fifo_on  = ctrl_r[CB_MODE_LSB +: 2] != MODE_OFF;
  assign wm_mode  = ctrl_r[CB_MODE_LSB +: 2] == MODE_WM;
  // Level zero means the full depth
  assign wm_n     = (ctrl_r[CB_WM_LSB +: 8] == 8'h00) ? DEPTH
                    : {1'b0, ctrl_r[CB_WM_LSB +: 8]};
  assign clr      = ctrl_wr_in & fifo_on;
  assign do_wr    = pend_r & ~lock & fifo_on & ~clr;
  assign wm_full  = wm_mode & (cnt_r == wm_n);
  assign store    = do_wr & ~wm_full;
  assign ovw      = store & ~wm_mode & (cnt_r == DEPTH);
  assign do_pop   = pop_ev & lock & (cnt_r != 9'h000) & ~rd_zero_r;
  assign empty_rd = pop_ev & lock & (cnt_r == 9'h000);
  assign last_pop = do_pop & (cnt_r == 9'h001);
  // Second result while one still waits: the older is lost
  assign wr_err_ev = (conv_valid_in & pend_r & ~do_wr)
                     | (do_wr & wm_full);
  assign head     = mem_r[rd_ptr_r];

  // Limit check with hysteresis on the upper result bits
  assign lim_en = channel_limit_check_enable_in[pend_ch_r];
  assign dval   = {1'b0, pend_data_r[23:12]};
  assign cmp_hi = lim_en & (hi_trip_r
                  ? (dval + HYST > {1'b0, upper_limit_value_in})
                  : (dval > {1'b0, upper_limit_value_in}));
  assign cmp_lo = lim_en & (lo_trip_r
                  ? (dval < {1'b0, lower_limit_value_in} + HYST)
                  : (dval < {1'b0, lower_limit_value_in}));

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = 9'h000;
    end else if (store && !ovw) begin
      cnt_nxt = cnt_r + 9'h001;
    end else if (do_pop) begin
      cnt_nxt = cnt_r - 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_wr_in) begin
      ctrl_r <= ctrl_data_in;
    end
  end

  // ----------------------------------------------------------------
  // Pending conversion, held off while the serial side reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_r      <= 1'b0;
      pend_data_r <= 24'h000000;
      pend_ch_r   <= 4'h0;
    end else if (clr) begin
      pend_r <= 1'b0;
    end else if (conv_valid_in && fifo_on) begin
      pend_r      <= 1'b1;
      pend_data_r <= conv_data_in;
      pend_ch_r   <= channel_index_in;
    end else if (do_wr) begin
      pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (store) begin
      // Tag built at write time
      mem_r[wr_ptr_r] <= {pend_data_r[23:8], 1'b0, cmp_hi | cmp_lo,
                          cnt_nxt >= wm_n, 1'b0, pend_ch_r};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_ptr_r  <= 8'h00;
      rd_ptr_r  <= 8'h00;
      cnt_r     <= 9'h000;
      hi_trip_r <= 1'b0;
      lo_trip_r <= 1'b0;
    end else if (clr) begin
      wr_ptr_r  <= 8'h00;
      rd_ptr_r  <= 8'h00;
      cnt_r     <= 9'h000;
      hi_trip_r <= 1'b0;
      lo_trip_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (do_wr) begin
        hi_trip_r <= cmp_hi;
        lo_trip_r <= cmp_lo;
      end
      if (store) begin
        wr_ptr_r <= wr_ptr_r + 8'h01;
      end
      // Oldest entry dropped to make room
      if (ovw || do_pop) begin
        rd_ptr_r <= rd_ptr_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags; a set in the same cycle beats any clear but the control-write clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stat_r <= STATUS_RST[6:0];
    end else if (clr) begin
      stat_r <= STATUS_RST[6:0];
    end else begin
      if (last_pop || empty_rd) begin
        stat_r[SB_EMPTY] <= 1'b1;
      end else if (store) begin
        stat_r[SB_EMPTY] <= 1'b0;
      end
      stat_r[SB_LEVEL] <= cnt_nxt >= wm_n;
      if ((do_wr && wm_full) || ovw) begin
        stat_r[SB_OVR] <= 1'b1;
      end else if (last_pop) begin
        stat_r[SB_OVR] <= 1'b0;
      end
      if (store && cmp_lo) begin
        stat_r[SB_LO] <= 1'b1;
      end else if (last_pop) begin
        stat_r[SB_LO] <= 1'b0;
      end
      if (store && cmp_hi) begin
        stat_r[SB_HI] <= 1'b1;
      end else if (last_pop) begin
        stat_r[SB_HI] <= 1'b0;
      end
      if (grant_ev && pend_r) begin
        stat_r[SB_RDERR] <= 1'b1;
      end else if (grant_ev || last_pop) begin
        stat_r[SB_RDERR] <= 1'b0;
      end
      if (wr_err_ev) begin
        stat_r[SB_WRERR] <= 1'b1;
      end else if (last_pop) begin
        stat_r[SB_WRERR] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward the host and the interrupt pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_err_r <= 1'b0;
      irq_out    <= 1'b0;
      rdy_r      <= 1'b0;
      rd_zero_r  <= 1'b0;
    end else begin
      ctrl_err_r <= ctrl_err_in;
      irq_out    <= |(stat_r & ctrl_r[CB_IEN_LSB +: 7]);
      // Busy while a write waits; watermark mode also below level
      rdy_r <= fifo_on & (pend_r | (wm_mode & (cnt_r < wm_n)));
      if (grant_ev) begin
        rd_zero_r <= pend_r;
      end else if (!lock) begin
        rd_zero_r <= 1'b0;
      end
    end
  end

  assign ctrl_out         = ctrl_r;
  assign queue_status_out = {ctrl_err_r, stat_r};

  // ----------------------------------------------------------------
  // Staging toward the serial clock; stable long before it is sampled
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stage_word_r <= {16'h0000, TAG_RST};
      stage_stat_r <= STATUS_RST;
      cfg_r        <= 12'h000;
    end else begin
      if (rd_zero_r) begin
        stage_word_r <= {16'h0000, TAG_RST};
      end else if (cnt_r == 9'h000) begin
        stage_word_r <= {16'h0000, TAG_DRAINED};
      end else begin
        stage_word_r <= {head[23:8], head[7:5], cnt_r == 9'h001,
                         head[3:0]};
      end
      stage_stat_r <= {ctrl_err_r, stat_r};
      if (!lock) begin
        // Checksum only with tag on and status off
        cfg_r <= {crc_enable_in & ~ctrl_r[CB_ADD_STAT] & ctrl_r[CB_ADD_TAG],
                  ctrl_r[CB_ADD_STAT], ctrl_r[CB_ADD_TAG], wm_n};
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial clock domain: frame held in reset while chip select high
  // ----------------------------------------------------------------
  arfsi_phase_t ph_r;
  logic        frame_rst_n;
  logic [4:0]  bcnt_r;
  logic [15:0] cmd_sr_r;
  logic [23:0] osr_r;
  logic [8:0]  left_r;
  logic [8:0]  blk_r;
  logic [15:0] crc_r;
  logic        dbit_r;
  logic [15:0] cmd_word;
  logic [4:0]  wl;
  logic        crc_in;
  logic [15:0] crc_step;
  logic [23:0] load_word;

  assign frame_rst_n = ~cs_n_in;
  assign cmd_word    = {cmd_sr_r[14:0], din_in};
  assign wl          = cfg_r[9] ? TSMP_BITS : SMP_BITS;
  assign crc_in      = (ph_r == ARFSI_CMD) ? din_in : osr_r[23];
  assign crc_step    = {crc_r[14:0], 1'b0}
                       ^ ((crc_r[15] ^ crc_in) ? CRC_POLY : 16'h0000);
  assign load_word   = cfg_r[9] ? stage_word_r
                       : {stage_word_r[23:8], 8'h00};

  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ph_r      <= ARFSI_CMD;
      bcnt_r    <= 5'h00;
      cmd_sr_r  <= 16'h0000;
      osr_r     <= 24'h000000;
      left_r    <= 9'h000;
      blk_r     <= 9'h000;
      crc_r     <= CRC_INIT;
      pop_tgl_r <= 1'b0;
    end else begin
      bcnt_r <= bcnt_r + 5'h01;
      osr_r  <= {osr_r[22:0], 1'b0};
      unique case (ph_r)
        ARFSI_CMD: begin
          cmd_sr_r <= cmd_word;
          crc_r    <= crc_step;
          if (bcnt_r == STAT_AT && cfg_r[10]) begin
            osr_r <= {stage_stat_r, 16'h0000};
          end
          if (bcnt_r == CMD_BITS - 5'h01) begin
            bcnt_r <= 5'h00;
            if (cmd_word[15:8] == READ_CMD) begin
              ph_r      <= ARFSI_SMP;
              osr_r     <= load_word;
              pop_tgl_r <= ~pop_tgl_r;
              left_r    <= (cmd_word[7:0] == 8'h00) ? DEPTH
                           : {1'b0, cmd_word[7:0]};
            end else begin
              ph_r <= ARFSI_DONE;
            end
          end
        end
        ARFSI_SMP: begin
          crc_r <= crc_step;
          if (bcnt_r == wl - 5'h01) begin
            bcnt_r <= 5'h00;
            left_r <= left_r - 9'h001;
            blk_r  <= blk_r + 9'h001;
            if (cfg_r[11] && blk_r + 9'h001 == cfg_r[8:0]) begin
              ph_r  <= ARFSI_CRC;
              osr_r <= {crc_step, 8'h00};
              crc_r <= CRC_INIT;
              blk_r <= 9'h000;
            end else if (left_r == 9'h001) begin
              ph_r <= ARFSI_DONE;
            end else begin
              osr_r     <= load_word;
              pop_tgl_r <= ~pop_tgl_r;
            end
          end
        end
        ARFSI_CRC: begin
          if (bcnt_r == CRC_BITS - 5'h01) begin
            bcnt_r <= 5'h00;
            if (left_r == 9'h000) begin
              ph_r <= ARFSI_DONE;
            end else begin
              ph_r      <= ARFSI_SMP;
              osr_r     <= load_word;
              pop_tgl_r <= ~pop_tgl_r;
            end
          end
        end
        ARFSI_DONE: begin
          bcnt_r <= 5'h00;
        end
      endcase
    end
  end

  // Launch on the falling edge so the host samples on the rising one
  always_ff @(negedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      dbit_r <= 1'b0;
    end else begin
      dbit_r <= osr_r[23];
    end
  end

  assign dout_out = cs_n_in ? rdy_r : dbit_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_CLR_EMPTIES: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    clr |=> (cnt_r == 9'h000) && stat_r[SB_EMPTY] && !stat_r[SB_HI])
    else $error("Control write did not empty the queue");
  AST_NO_WR_LOCK: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    lock && lock_d_r |=> $stable(wr_ptr_r))
    else $error("Result written while serial side held the queue");
  AST_RDY_WM: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    fifo_on && wm_mode && !pend_r && cnt_r >= wm_n |=> !rdy_r)
    else $error("Busy shown although level was reached");
  AST_LEVEL: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    cnt_nxt >= wm_n |=> stat_r[SB_LEVEL])
    else $error("Level flag missing at or above fill level");
  AST_IRQ_OR: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    (|(stat_r & ctrl_r[CB_IEN_LSB +: 7])) |=> irq_out)
    else $error("Enabled source did not raise the interrupt");
  AST_EMPTY_POP: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    last_pop |=> stat_r[SB_EMPTY] && cnt_r == 9'h000 && !stat_r[SB_OVR])
    else $error("Last read did not drain the queue");
  AST_OVW_OVR: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    ovw |=> stat_r[SB_OVR] && cnt_r == DEPTH)
    else $error("Overwrite did not flag data lost");
  AST_WM_DROP: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    do_wr && wm_full |=> stat_r[SB_WRERR] && $stable(cnt_r))
    else $error("Write at fill level not refused");
  AST_RDERR: assert property (@(posedge clk_in) disable iff (!rst_n_r)
    grant_ev && pend_r |=> ##1 stat_r[SB_RDERR] && stage_word_r == 24'h0)
    else $error("Read during write not flagged or not zeroed");
endmodule

// file: shared/arfsi_pkg.sv
// Constants and types for the conversion-result queue block
package arfsi_pkg;
  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS    = 8'h3a;
  localparam logic [7:0]  STATUS_OFS  = 8'h3b;
  localparam logic [23:0] CTRL_RST    = 24'h040200;
  localparam logic [7:0]  STATUS_RST  = 8'h01;
  localparam logic [7:0]  TAG_RST     = 8'h00;
  localparam logic [7:0]  TAG_DRAINED = 8'h10;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CB_WM_LSB   = 0;
  localparam int CB_IEN_LSB  = 8;
  localparam int CB_MODE_LSB = 16;
  localparam int CB_ADD_TAG  = 18;
  localparam int CB_ADD_STAT = 19;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_WM  = 2'h1;

  // ----------------------------------------------------------------
  // Status and tag bits
  // ----------------------------------------------------------------
  localparam int SB_EMPTY = 0;
  localparam int SB_LEVEL = 1;
  localparam int SB_OVR   = 2;
  localparam int SB_LO    = 3;
  localparam int SB_HI    = 4;
  localparam int SB_RDERR = 5;
  localparam int SB_WRERR = 6;
  localparam int TB_EMPTY = 4;
  localparam int TB_LEVEL = 5;
  localparam int TB_LIMIT = 6;

  // ----------------------------------------------------------------
  // Serial frame, checksum, depth
  // ----------------------------------------------------------------
  localparam logic [7:0]  READ_CMD  = 8'h7d;
  localparam logic [4:0]  CMD_BITS  = 5'h10;
  localparam logic [4:0]  SMP_BITS  = 5'h10;
  localparam logic [4:0]  TSMP_BITS = 5'h18;
  localparam logic [4:0]  CRC_BITS  = 5'h10;
  localparam logic [4:0]  STAT_AT   = 5'h07;
  localparam logic [15:0] CRC_POLY  = 16'ha2eb;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [8:0]  DEPTH     = 9'h100;
  localparam logic [12:0] HYST      = 13'h0002;

  typedef enum logic [1:0] {
    ARFSI_CMD,
    ARFSI_SMP,
    ARFSI_CRC,
    ARFSI_DONE
  } arfsi_phase_t;
endpackage

// file: verif/arfsi_host.sv
// Host serial controller model for queue burst readback
module arfsi_host
  import arfsi_pkg::*;
(
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  input  wire logic dout_in
);
  timeunit 1ns;
  timeprecision 100ps;

  bit rx[$];

  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end

  // ----------------------------------------------------------------
  // Burst read; clock stands high outside frames
  // ----------------------------------------------------------------
  task automatic burst(input logic [7:0] n, input int nbits);
    logic [15:0] hd;
    hd = {READ_CMD, n};
    rx.delete();
    #13;
    cs_n_out = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      sclk_out = 1'b0;
      // Data line driven low once the command is sent
      din_out  = (i < 16) ? hd[15-i] : 1'b0;
      #40;
      sclk_out = 1'b1;
      rx.push_back(dout_in);
      #40;
    end
    cs_n_out = 1'b1;
  endtask
endmodule

// file: verif/tb_adc_result_fifo_status_irq.sv
// Self-checking bench for the result queue readback and flags
module tb_adc_result_fifo_status_irq
  import arfsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 0, arst_n = 0, cv = 0, wr = 0, crc_en = 0, cerr = 0;
  logic [23:0] cd = '0, wd = '0;
  logic [3:0]  ch = '0;
  logic [7:0]  lvl;
  wire         sclk, cs_n, din, dout, irq;
  wire  [23:0] ctrl;
  wire  [7:0]  st;
  int          fail_count = 0, num_checks = 0;
  int          mq[$];

  arfsi_host u_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
                     .dout_in(dout));
  arfsi_top u_dut (.clk_in(clk), .arst_n_in(arst_n), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .conv_valid_in(cv),
    .conv_data_in(cd), .channel_index_in(ch),
    .channel_limit_check_enable_in(16'h0000),
    .upper_limit_value_in(12'hfff), .lower_limit_value_in(12'h000),
    .ctrl_wr_in(wr), .ctrl_data_in(wd), .crc_enable_in(crc_en),
    .ctrl_err_in(cerr), .ctrl_out(ctrl), .queue_status_out(st),
    .irq_out(irq));

  initial forever #20 clk = ~clk;
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] field(input int pos, input int len);
    logic [23:0] v = '0;
    for (int i = 0; i < len; i++) v = {v[22:0], logic'(u_host.rx[pos+i])};
    return v;
  endfunction

  function automatic logic [15:0] crc(input logic [15:0] c,
                                     input logic [23:0] v, input int len);
    for (int i = len - 1; i >= 0; i--)
      c = (c[15] ^ v[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction

  task automatic wctl(input logic tag);
    @(posedge clk);
    #1 wr = 1;
    wd = {4'h0, 1'b0, tag, MODE_WM, 1'b0, 7'h02, lvl};
    @(posedge clk);
    #1 wr = 0;
    chk(ctrl, wd);
    @(posedge clk);
    #1 chk(st, {cerr, 7'h01});
  endtask

  task automatic conv();
    @(posedge clk);
    #1 cv = 1;
    cd = $urandom();
    ch = $urandom();
    mq.push_back({ch, cd[23:8]});
    @(posedge clk);
    #1 cv = 0;
    chk(dout, 1'b1);
    repeat (4) @(posedge clk);
  endtask

  task automatic rd(input int n, input logic tag, input logic ck);
    int          w = tag ? 24 : 16;
    logic [23:0] e;
    logic [15:0] c = crc(CRC_INIT, {8'h0, READ_CMD, n[7:0]}, 16);
    u_host.burst(n[7:0], 16 + n * w + (ck ? 16 : 0));
    for (int s = 0; s < n; s++) begin
      e = mq.pop_front();
      e = {e[15:0], 2'b00, (s + 1 >= lvl), (s == n - 1), e[19:16]};
      if (!tag) e = {8'h0, e[23:8]};
      chk(field(16 + s * w, w), e);
      c = crc(c, e, w);
    end
    if (ck) chk(field(16 + n * w, 16), c);
    repeat (5) @(posedge clk);
    #1;
    chk(st[1:0], 2'b01);
    chk(irq, 1'b0);
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h3dd8));
    repeat (6) @(posedge clk);
    #1 arst_n = 1;
    cerr = $urandom();
    repeat (3) @(posedge clk);
    #1;
    chk(ctrl, CTRL_RST);
    chk(st, {cerr, STATUS_RST[6:0]});
    for (int k = 0; k < 3; k++) begin
      lvl = 8'h2 + k;
      crc_en = (k == 1);
      wctl(k != 2);
      for (int j = 0; j < lvl; j++) conv();
      #1;
      chk(st[1:0], 2'b10);
      chk(irq, 1'b1);
      chk(dout, 1'b0);
      rd(lvl, k != 2, k == 1);
    end
    complete_run();
  end
endmodule
